// ==== verilog/rpe_defs.svh ====
// Register map, field positions, reset values and timing for the receive port equalizer block
`ifndef RPE_DEFS_SVH
`define RPE_DEFS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define RPE_IDX_ADAPT_CTRL 8'hd2
`define RPE_IDX_EQ_STATE   8'hd3
`define RPE_IDX_MANUAL     8'hd4
`define RPE_IDX_LIMITS     8'hd5
`define RPE_IDX_IRQ_EN     8'hd8
`define RPE_IDX_IRQ_STS    8'hda
`define RPE_IDX_PORT_STS1  8'he0
`define RPE_IDX_PORT_STS2  8'he1

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RPE_ADAPT_OFF_BIT  0
`define RPE_LOCK_WAIT_BIT  4
`define RPE_UPPER_MSB      7
`define RPE_UPPER_LSB      5
`define RPE_LOWER_MSB      3
`define RPE_LOWER_LSB      1
`define RPE_LIMIT_MSB      7
`define RPE_LIMIT_LSB      4
`define RPE_FLOOR_MSB      3
`define RPE_FLOOR_LSB      0
`define RPE_FLOOR_EN_BIT   2
`define RPE_RERUN_BIT      3
`define RPE_EV_ENC         2
`define RPE_EV_SEQ         1
`define RPE_EV_CRC         0
`define RPE_STS1_LOCK_BIT  2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RPE_RST_MANUAL     8'h60
`define RPE_RST_LIMITS     8'hf8
`define RPE_RST_IRQ_EN     3'h0
`define RPE_RST_FLOOR_EN   1'h1

// ----------------------------------------
// Timing: adaptation step wait, least time rounded up
// ----------------------------------------
`define RPE_STEP_TIME_NS   164000
`define RPE_CLK_PERIOD_NS  50
`define RPE_STEP_CYCLES    ((`RPE_STEP_TIME_NS + `RPE_CLK_PERIOD_NS - 1) / `RPE_CLK_PERIOD_NS)

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define RPE_RESP_OKAY      2'h0
`define RPE_RESP_DECERR    2'h3

`endif

// ==== verilog/rpe_pkg.sv ====
// Types and shared decode function for the receive port equalizer block
package rpe_pkg;

   // Equalizer search states
   typedef enum logic [1:0] {
      RPE_SRCH_LOAD,
      RPE_SRCH_WAIT,
      RPE_SRCH_DONE
   } rpe_srch_t;

   // Six bit equalizer level
   typedef logic [5:0] rpe_level_t;

   // Byte address to register index
   function automatic logic [7:0] rpe_idx(input logic [9:0] addr);
      return addr[9:2];
   endfunction

endpackage

// ==== verilog/rpe_eq_search.sv ====
// Adaptive equalizer level search with limit, floor start and manual override
`timescale 1ns/1ps
`include "rpe_defs.svh"

module rpe_eq_search
   import rpe_pkg::*;
(
   // Clock and reset
   input  logic       sys_clk,
   input  logic       rstn,
   input  logic       clk_en,
   // Controls
   input  logic       adapt_off,
   input  rpe_level_t manual_level,
   input  logic [3:0] upper_limit,
   input  logic [3:0] start_floor,
   input  logic       floor_en,
   input  logic       rerun,
   input  logic       locked_in,
   // Results
   output rpe_level_t eq_level,
   output logic       adapt_done
);

   localparam logic [11:0] STEP_LAST = 12'(`RPE_STEP_CYCLES - 1);

   rpe_srch_t  state_q;
   logic [11:0] cnt_q;
   rpe_level_t level_q;
   logic       done_q;

   // ----------------------------------------
   // Limit and start level
   // ----------------------------------------
   wire rpe_level_t cap      = {upper_limit, 2'b11};
   wire rpe_level_t floor_lv = floor_en ? {start_floor, 2'b00} : 6'h00;
   wire rpe_level_t start_lv = (floor_lv > cap) ? cap : floor_lv;
   wire             at_cap   = (level_q >= cap);

   assign eq_level   = level_q;
   assign adapt_done = done_q;

   // ----------------------------------------
   // Search sequence
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= RPE_SRCH_LOAD;
         cnt_q   <= 12'h000;
         level_q <= 6'h00;
         done_q  <= 1'b0;
      end else if (clk_en) begin
         if (adapt_off) begin
            level_q <= manual_level;
            done_q  <= 1'b1;
            state_q <= RPE_SRCH_LOAD;
         end else if (rerun) begin
            done_q  <= 1'b0;
            state_q <= RPE_SRCH_LOAD;
         end else begin
            case (state_q)
               RPE_SRCH_LOAD: begin
                  level_q <= start_lv;
                  cnt_q   <= 12'h000;
                  done_q  <= 1'b0;
                  state_q <= RPE_SRCH_WAIT;
               end
               RPE_SRCH_WAIT: begin
                  if (locked_in) begin
                     state_q <= RPE_SRCH_DONE;
                     done_q  <= 1'b1;
                  end else if (level_q > cap) begin
                     level_q <= start_lv;
                  end else if (cnt_q == STEP_LAST) begin
                     cnt_q   <= 12'h000;
                     level_q <= at_cap ? start_lv : level_q + 6'h01;
                  end else begin
                     cnt_q <= cnt_q + 12'h001;
                  end
               end
               RPE_SRCH_DONE: begin
                  if (level_q > cap) level_q <= cap;
                  if (!locked_in) begin
                     state_q <= RPE_SRCH_LOAD;
                     done_q  <= 1'b0;
                  end
               end
               default: state_q <= RPE_SRCH_LOAD;
            endcase
         end
      end
   end

endmodule // rpe_eq_search

// ==== verilog/rpe_regs.sv ====
// Receive port equalizer and error interrupt register bank with AXI4-Lite slave
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "rpe_defs.svh"

module rpe_regs
   import rpe_pkg::*;
(
   // Clock, reset, enable
   input  logic        sys_clk,
   input  logic        rstn,
   input  logic        clk_en,
   // AXI4-Lite write address
   input  logic [9:0]  s_axi_awaddr,
   input  logic        s_axi_awvalid,
   output logic        s_axi_awready,
   // AXI4-Lite write data
   input  logic [31:0] s_axi_wdata,
   input  logic [3:0]  s_axi_wstrb,
   input  logic        s_axi_wvalid,
   output logic        s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]  s_axi_bresp,
   output logic        s_axi_bvalid,
   input  logic        s_axi_bready,
   // AXI4-Lite read address
   input  logic [9:0]  s_axi_araddr,
   input  logic        s_axi_arvalid,
   output logic        s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0]  s_axi_rresp,
   output logic        s_axi_rvalid,
   input  logic        s_axi_rready,
   // Link side inputs
   input  logic        lock_detect,
   input  logic        link_encoding_error_evt,
   input  logic        ctrl_channel_sequence_evt,
   input  logic        ctrl_channel_crc_evt,
   // Block outputs
   output rpe_level_t  eq_level,
   output logic        rx_lock,
   output logic        irq
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic       awrdy_q;
   logic       aw_held_q;
   logic [7:0] wr_idx_q;
   logic       wrdy_q;
   logic       w_held_q;
   logic [7:0] wdata_q;
   logic       wlane_q;
   logic       bvalid_q;
   logic [1:0] bresp_q;
   logic       arrdy_q;
   logic       rvalid_q;
   logic [7:0] rdata_q;
   logic [1:0] rresp_q;

   logic [7:0] manual_q;
   logic [7:0] limits_q;
   logic       floor_en_q;
   logic       rerun_q;
   logic [2:0] irq_en_q;
   logic [2:0] irq_sts_q;
   logic       enc_flag_q;
   logic       seq_flag_q;
   logic       crc_flag_q;
   logic       lock_s1_q;
   logic       lock_s2_q;
   logic       rx_lock_q;
   logic       irq_q;

   rpe_level_t level;
   logic       adapt_done;

   // ----------------------------------------
   // Write channel handshakes
   // ----------------------------------------
   wire aw_take  = clk_en & s_axi_awvalid & awrdy_q;
   wire w_take   = clk_en & s_axi_wvalid & wrdy_q;
   wire wr_fire  = clk_en & aw_held_q & w_held_q & ~bvalid_q;
   wire aw_hld_d = (aw_held_q | aw_take) & ~wr_fire;
   wire w_hld_d  = (w_held_q | w_take) & ~wr_fire;
   wire b_done   = clk_en & bvalid_q & s_axi_bready;

   // Write decode
   wire wr_en     = wr_fire & wlane_q;
   wire wr_ctrl   = wr_en & (wr_idx_q == `RPE_IDX_ADAPT_CTRL);
   wire wr_manual = wr_en & (wr_idx_q == `RPE_IDX_MANUAL);
   wire wr_limits = wr_en & (wr_idx_q == `RPE_IDX_LIMITS);
   wire wr_irq_en = wr_en & (wr_idx_q == `RPE_IDX_IRQ_EN);
   wire wr_hit    = (wr_idx_q == `RPE_IDX_ADAPT_CTRL) | (wr_idx_q == `RPE_IDX_EQ_STATE) |
                    (wr_idx_q == `RPE_IDX_MANUAL)     | (wr_idx_q == `RPE_IDX_LIMITS)   |
                    (wr_idx_q == `RPE_IDX_IRQ_EN)     | (wr_idx_q == `RPE_IDX_IRQ_STS)  |
                    (wr_idx_q == `RPE_IDX_PORT_STS1)  | (wr_idx_q == `RPE_IDX_PORT_STS2);

   // ----------------------------------------
   // Read channel handshakes and decode
   // ----------------------------------------
   wire       ar_take  = clk_en & s_axi_arvalid & arrdy_q;
   wire       rv_d     = (rvalid_q & ~(clk_en & s_axi_rready)) | ar_take;
   wire [7:0] rd_idx   = rpe_idx(s_axi_araddr);
   wire       rd_sts1  = ar_take & (rd_idx == `RPE_IDX_PORT_STS1);
   wire       rd_sts2  = ar_take & (rd_idx == `RPE_IDX_PORT_STS2);
   wire       rd_isr   = ar_take & (rd_idx == `RPE_IDX_IRQ_STS);

   // Read values
   wire [7:0] rv_ctrl  = {4'h0, rerun_q, floor_en_q, 2'b00};
   wire [7:0] rv_state = {2'b00, level};
   wire [7:0] rv_ien   = {5'h00, irq_en_q};
   wire [7:0] rv_isr   = {5'h00, irq_sts_q};
   wire [7:0] rv_sts1  = {5'h00, rx_lock_q, seq_flag_q, crc_flag_q};
   wire [7:0] rv_sts2  = {7'h00, enc_flag_q};

   // Read selection
   wire [7:0] rd_mux =
      (rd_idx == `RPE_IDX_ADAPT_CTRL) ? rv_ctrl  :
      (rd_idx == `RPE_IDX_EQ_STATE)   ? rv_state :
      (rd_idx == `RPE_IDX_MANUAL)     ? manual_q :
      (rd_idx == `RPE_IDX_LIMITS)     ? limits_q :
      (rd_idx == `RPE_IDX_IRQ_EN)     ? rv_ien   :
      (rd_idx == `RPE_IDX_IRQ_STS)    ? rv_isr   :
      (rd_idx == `RPE_IDX_PORT_STS1)  ? rv_sts1  :
      (rd_idx == `RPE_IDX_PORT_STS2)  ? rv_sts2  : 8'h00;
   wire rd_hit =
      (rd_idx == `RPE_IDX_ADAPT_CTRL) | (rd_idx == `RPE_IDX_EQ_STATE) |
      (rd_idx == `RPE_IDX_MANUAL)     | (rd_idx == `RPE_IDX_LIMITS)   |
      (rd_idx == `RPE_IDX_IRQ_EN)     | (rd_idx == `RPE_IDX_IRQ_STS)  |
      (rd_idx == `RPE_IDX_PORT_STS1)  | (rd_idx == `RPE_IDX_PORT_STS2);

   // ----------------------------------------
   // Event flags: set wins over read clear
   // ----------------------------------------
   wire [2:0] ev = {link_encoding_error_evt, ctrl_channel_sequence_evt, ctrl_channel_crc_evt};
   wire [2:0] ev_on = {3{clk_en}} & ev;
   wire [2:0] isr_clr = {rd_sts2, rd_sts1, rd_sts1} | {3{rd_isr}};
   wire [2:0] isr_d = ev_on | (irq_sts_q & ~isr_clr);

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign s_axi_awready = awrdy_q;
   assign s_axi_wready  = wrdy_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arrdy_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = {24'h000000, rdata_q};
   assign s_axi_rresp   = rresp_q;
   assign eq_level      = level;
   assign rx_lock       = rx_lock_q;
   assign irq           = irq_q;

   // ----------------------------------------
   // Write address and data capture
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         aw_held_q <= 1'b0;
         awrdy_q   <= 1'b0;
         wr_idx_q  <= 8'h00;
         w_held_q  <= 1'b0;
         wrdy_q    <= 1'b0;
         wdata_q   <= 8'h00;
         wlane_q   <= 1'b0;
      end else if (clk_en) begin
         aw_held_q <= aw_hld_d;
         awrdy_q   <= ~aw_hld_d;
         w_held_q  <= w_hld_d;
         wrdy_q    <= ~w_hld_d;
         if (aw_take) wr_idx_q <= rpe_idx(s_axi_awaddr);
         if (w_take) begin
            wdata_q <= s_axi_wdata[7:0];
            wlane_q <= s_axi_wstrb[0];
         end
      end
   end

   // Write response
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `RPE_RESP_OKAY;
      end else if (clk_en) begin
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? `RPE_RESP_OKAY : `RPE_RESP_DECERR;
         end else if (b_done) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Read address and data
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         arrdy_q  <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q  <= 8'h00;
         rresp_q  <= `RPE_RESP_OKAY;
      end else if (clk_en) begin
         arrdy_q  <= ~rv_d;
         rvalid_q <= rv_d;
         if (ar_take) begin
            rdata_q <= rd_mux;
            rresp_q <= rd_hit ? `RPE_RESP_OKAY : `RPE_RESP_DECERR;
         end
      end
   end

   // ----------------------------------------
   // Software control registers
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         manual_q   <= `RPE_RST_MANUAL;
         limits_q   <= `RPE_RST_LIMITS;
         floor_en_q <= `RPE_RST_FLOOR_EN;
         irq_en_q   <= `RPE_RST_IRQ_EN;
      end else if (clk_en) begin
         if (wr_manual) manual_q <= wdata_q;
         if (wr_limits) limits_q <= wdata_q;
         if (wr_ctrl) floor_en_q <= wdata_q[`RPE_FLOOR_EN_BIT];
         if (wr_irq_en) irq_en_q <= wdata_q[2:0];
      end
   end

   // Self clearing rerun request
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rerun_q <= 1'b0;
      end else if (clk_en) begin
         rerun_q <= wr_ctrl & wdata_q[`RPE_RERUN_BIT];
      end
   end

   // ----------------------------------------
   // Status flags and interrupt
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq_sts_q  <= 3'h0;
         enc_flag_q <= 1'b0;
         seq_flag_q <= 1'b0;
         crc_flag_q <= 1'b0;
         irq_q      <= 1'b0;
      end else if (clk_en) begin
         irq_sts_q  <= isr_d;
         enc_flag_q <= ev_on[`RPE_EV_ENC] | (enc_flag_q & ~rd_sts2);
         seq_flag_q <= ev_on[`RPE_EV_SEQ] | (seq_flag_q & ~rd_sts1);
         crc_flag_q <= ev_on[`RPE_EV_CRC] | (crc_flag_q & ~rd_sts1);
         irq_q      <= |(irq_sts_q & irq_en_q);
      end
   end

   // ----------------------------------------
   // Lock detector synchroniser and lock qualify
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         lock_s1_q <= 1'b0;
         lock_s2_q <= 1'b0;
         rx_lock_q <= 1'b0;
      end else if (clk_en) begin
         lock_s1_q <= lock_detect;
         lock_s2_q <= lock_s1_q;
         rx_lock_q <= lock_s2_q & (~manual_q[`RPE_LOCK_WAIT_BIT] | adapt_done);
      end
   end

   // ----------------------------------------
   // Equalizer search engine
   // ----------------------------------------
   rpe_eq_search u_search (
      .sys_clk      (sys_clk),
      .rstn         (rstn),
      .clk_en       (clk_en),
      .adapt_off    (manual_q[`RPE_ADAPT_OFF_BIT]),
      .manual_level ({manual_q[`RPE_UPPER_MSB:`RPE_UPPER_LSB],
                      manual_q[`RPE_LOWER_MSB:`RPE_LOWER_LSB]}),
      .upper_limit  (limits_q[`RPE_LIMIT_MSB:`RPE_LIMIT_LSB]),
      .start_floor  (limits_q[`RPE_FLOOR_MSB:`RPE_FLOOR_LSB]),
      .floor_en     (floor_en_q),
      .rerun        (rerun_q),
      .locked_in    (lock_s2_q),
      .eq_level     (level),
      .adapt_done   (adapt_done)
   );

endmodule // rpe_regs

// ==== verification/rpe_regs_props.sv ====
// Port level checker of the receive port equalizer register bank
`timescale 1ns/1ps
`include "rpe_defs.svh"

module rpe_regs_props
   import rpe_pkg::*;
(
   // Clock and reset
   input logic        sys_clk,
   input logic        rstn,
   // Register bus
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic [9:0]  s_axi_araddr,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready,
   input logic [31:0] s_axi_rdata,
   input logic [1:0]  s_axi_rresp,
   // Link side and outputs
   input logic        lock_detect,
   input logic        link_encoding_error_evt,
   input logic        ctrl_channel_sequence_evt,
   input logic        ctrl_channel_crc_evt,
   input rpe_level_t  eq_level,
   input logic        rx_lock,
   input logic        irq
);
   logic [7:0] ar_idx_q;
   wire        ar_hs  = s_axi_arvalid & s_axi_arready;
   wire        ev_any = link_encoding_error_evt | ctrl_channel_sequence_evt | ctrl_channel_crc_evt;

   // Index of the read under way
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) ar_idx_q <= 8'h00;
      else if (ar_hs) ar_idx_q <= s_axi_araddr[9:2];
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   // ----------------------------------------
   // Bus timing
   // ----------------------------------------
   property p_rd_lat; ar_hs |=> s_axi_rvalid; endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer not next cycle");
   property p_wr_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[2:3] s_axi_bvalid;
   endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
   property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_b_once: assert property (p_b_once) else $error("write answer repeated");
   property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_r_once: assert property (p_r_once) else $error("read answer repeated");

   // ----------------------------------------
   // Register contents and link behaviour
   // ----------------------------------------
   property p_state_rd;
      $rose(s_axi_rvalid) && ar_idx_q == `RPE_IDX_EQ_STATE |-> s_axi_rdata == {26'h0, $past(eq_level)};
   endproperty
   a_state_rd: assert property (p_state_rd) else $error("state readback wrong");
   property p_ien_rd; $rose(s_axi_rvalid) && ar_idx_q == `RPE_IDX_IRQ_EN |-> s_axi_rdata[31:3] == 29'h0; endproperty
   a_ien_rd: assert property (p_ien_rd) else $error("enable spare bits set");
   property p_lock; rx_lock |-> $past(lock_detect, 3); endproperty
   a_lock: assert property (p_lock) else $error("lock without detector");
   property p_irq_src; $rose(irq) |-> $past(ev_any, 2) || s_axi_bvalid || $past(s_axi_bvalid); endproperty
   a_irq_src: assert property (p_irq_src) else $error("interrupt without cause");
   property p_irq_clr; $fell(irq) |-> $past(ar_hs, 2) || s_axi_bvalid || $past(s_axi_bvalid); endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("interrupt dropped alone");

   // Main scenarios reached
   c_irq: cover property ($rose(irq));
   c_lock: cover property ($rose(rx_lock));
   c_dec: cover property (s_axi_rvalid && s_axi_rresp == `RPE_RESP_DECERR);
endmodule // rpe_regs_props

// ==== verification/rpe_link_model.sv ====
// Far side serializer model: lock detector level and link error events
`timescale 1ns/1ps

module rpe_link_model (
   // Clock
   input  logic sys_clk,
   // Link side outputs
   output logic lock_detect,
   output logic enc_evt,
   output logic seq_evt,
   output logic crc_evt
);
   // Quiet, unlocked link at start
   initial begin
      lock_detect = 1'b0;
      {enc_evt, seq_evt, crc_evt} = 3'h0;
   end

   // Lock moves off the clock grid, the detector is asynchronous
   task automatic set_lock(input logic v);
      #17 lock_detect = v;
   endtask

   // One cycle of events: bit 2 encoding, bit 1 sequence, bit 0 crc
   task automatic fire(input logic [2:0] m);
      @(posedge sys_clk);
      {enc_evt, seq_evt, crc_evt} <= m;
      @(posedge sys_clk);
      {enc_evt, seq_evt, crc_evt} <= 3'h0;
   endtask
endmodule // rpe_link_model

// ==== verification/testbench.sv ====
// Self-checking testbench of the receive port equalizer register bank
`timescale 1ns/1ps
`include "rpe_defs.svh"

module testbench
   import rpe_pkg::*;
;
   logic        sys_clk, rstn, rx_lock, irq;
   logic [9:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_bready, s_axi_rready;
   logic [3:0]  s_axi_wstrb;
   logic        lock_detect, enc_evt, seq_evt, crc_evt;
   rpe_level_t  eq_level;
   int          n_errors = 0;
   int          checks_done = 0;

   rpe_regs uut (
      .sys_clk(sys_clk), .rstn(rstn), .clk_en(1'b1),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .lock_detect(lock_detect),
      .link_encoding_error_evt(enc_evt), .ctrl_channel_sequence_evt(seq_evt),
      .ctrl_channel_crc_evt(crc_evt), .eq_level(eq_level), .rx_lock(rx_lock), .irq(irq)
   );
   rpe_link_model link (
      .sys_clk(sys_clk), .lock_detect(lock_detect), .enc_evt(enc_evt), .seq_evt(seq_evt), .crc_evt(crc_evt)
   );

   // 20 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // ----------------------------------------
   // Bus and compare helpers
   // ----------------------------------------
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] ix, input logic [7:0] d, output logic [1:0] rs);
      bit a, w;
      int n;
      a = 0;
      w = 0;
      n = 0;
      s_axi_awaddr <= {ix, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (!a && s_axi_awready === 1'b1) begin
            a = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready === 1'b1) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
         if (a && w && s_axi_bvalid !== 1'b1 && n < 50) s_axi_bready <= 1'b1;
      end while (!(a && w && s_axi_bvalid === 1'b1) && n < 50);
      s_axi_bready <= 1'b0;
      cmp("bvalid", 32'h1, 32'(s_axi_bvalid));
      rs = s_axi_bresp;
   endtask

   task automatic rd(input logic [7:0] ix, output logic [31:0] d, output logic [1:0] rs);
      bit a;
      int n;
      a = 0;
      n = 0;
      s_axi_araddr <= {ix, 2'b00};
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (!a && s_axi_arready === 1'b1) begin
            a = 1;
            s_axi_arvalid <= 1'b0;
         end
         if (a && s_axi_rvalid !== 1'b1 && n < 50) s_axi_rready <= 1'b1;
      end while (!(a && s_axi_rvalid === 1'b1) && n < 50);
      s_axi_rready <= 1'b0;
      cmp("rvalid", 32'h1, 32'(s_axi_rvalid));
      d = s_axi_rdata;
      rs = s_axi_rresp;
   endtask

   task automatic chk_rd(input logic [7:0] ix, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  rs;
      rd(ix, d, rs);
      cmp("rdata", e, d);
      cmp("rresp", 32'(`RPE_RESP_OKAY), 32'(rs));
   endtask

   // Bounded wait for the applied level, then compare
   task automatic wait_lvl(input rpe_level_t e);
      int n;
      n = 0;
      while (eq_level !== e && n < 20) begin
         @(posedge sys_clk);
         n++;
      end
      cmp("eq_level", 32'(e), 32'(eq_level));
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      logic [31:0] d;
      logic [1:0]  rs;
      chk_rd(`RPE_IDX_EQ_STATE, {26'h0, 4'h8, 2'b00});
      chk_rd(`RPE_IDX_MANUAL, 32'h60);
      chk_rd(`RPE_IDX_LIMITS, 32'hf8);
      chk_rd(`RPE_IDX_ADAPT_CTRL, 32'h04);
      chk_rd(`RPE_IDX_IRQ_EN, 32'h00);
      rd(8'h10, d, rs);
      cmp("unmapped", 32'(`RPE_RESP_DECERR), 32'(rs));
   endtask

   // Manual level {101,010} with adaptation off
   task automatic t_manual();
      logic [1:0] rs;
      wr(`RPE_IDX_MANUAL, 8'ha5, rs);
      wait_lvl(6'h2a);
      chk_rd(`RPE_IDX_EQ_STATE, 32'h2a);
      s_axi_wstrb <= 4'h0;
      wr(`RPE_IDX_MANUAL, 8'h00, rs);
      s_axi_wstrb <= 4'hf;
      cmp("bresp", 32'(`RPE_RESP_OKAY), 32'(rs));
      chk_rd(`RPE_IDX_MANUAL, 32'ha5);
      wr(`RPE_IDX_MANUAL, 8'h60, rs);
   endtask

   // Start clipped to the cap, rerun self clears, search never passes cap
   task automatic t_limits();
      logic [1:0] rs;
      rpe_level_t mx;
      wr(`RPE_IDX_LIMITS, 8'h45, rs);
      wr(`RPE_IDX_ADAPT_CTRL, 8'h0c, rs);
      wait_lvl(6'h13);
      chk_rd(`RPE_IDX_ADAPT_CTRL, 32'h04);
      wr(`RPE_IDX_LIMITS, 8'h00, rs);
      wr(`RPE_IDX_ADAPT_CTRL, 8'h08, rs);
      wait_lvl(6'h00);
      mx = 6'h00;
      repeat (4 * `RPE_STEP_CYCLES + 100) begin
         @(posedge sys_clk);
         if (eq_level > mx) mx = eq_level;
      end
      cmp("search max", 32'h3, 32'(mx));
      repeat (`RPE_STEP_CYCLES) @(posedge sys_clk);
      wait_lvl(6'h01);
      wr(`RPE_IDX_ADAPT_CTRL, 8'h08, rs);
      wait_lvl(6'h00);
   endtask

   // Each enabled event interrupts, the status read clears it
   task automatic t_irq();
      logic [1:0] rs;
      for (int k = 0; k < 3; k++) begin
         wr(`RPE_IDX_IRQ_EN, 8'(1 << k), rs);
         link.fire(3'(1 << k));
         repeat (3) @(posedge sys_clk);
         cmp("irq set", 32'h1, 32'(irq));
         chk_rd(k == 2 ? `RPE_IDX_PORT_STS2 : `RPE_IDX_PORT_STS1, k == 2 ? 32'h1 : 32'(1 << k));
         repeat (2) @(posedge sys_clk);
         cmp("irq clear", 32'h0, 32'(irq));
      end
      wr(`RPE_IDX_IRQ_EN, 8'hff, rs);
      chk_rd(`RPE_IDX_IRQ_EN, 32'h07);
      wr(`RPE_IDX_IRQ_EN, 8'h00, rs);
      link.fire(3'h7);
      repeat (3) @(posedge sys_clk);
      cmp("irq masked", 32'h0, 32'(irq));
      chk_rd(`RPE_IDX_PORT_STS1, 32'h03);
      chk_rd(`RPE_IDX_PORT_STS2, 32'h01);
      wr(`RPE_IDX_IRQ_EN, 8'h07, rs);
      repeat (3) @(posedge sys_clk);
      cmp("irq after clear", 32'h0, 32'(irq));
   endtask

   // Plain lock, then lock held back for adaptation
   task automatic t_lock();
      logic [1:0] rs;
      link.set_lock(1'b1);
      repeat (6) @(posedge sys_clk);
      cmp("rx_lock", 32'h1, 32'(rx_lock));
      chk_rd(`RPE_IDX_PORT_STS1, 32'h04);
      link.set_lock(1'b0);
      @(posedge sys_clk);
      wr(`RPE_IDX_MANUAL, 8'h70, rs);
      repeat (6) @(posedge sys_clk);
      cmp("rx_lock", 32'h0, 32'(rx_lock));
      link.set_lock(1'b1);
      repeat (10) @(posedge sys_clk);
      cmp("rx_lock", 32'h1, 32'(rx_lock));
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Watchdog well past the expected run of about 17000 cycles
   initial begin
      #(50 * 40000);
      n_errors++;
      wrap_up();
   end

   // Main sequence
   initial begin
      rstn = 1'b0;
      s_axi_awaddr = 10'h000;
      s_axi_araddr = 10'h000;
      s_axi_wdata = 32'h0;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_rready = 1'b0;
      s_axi_wstrb = 4'hf;
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      t_reset();
      t_manual();
      t_limits();
      t_irq();
      t_lock();
      wrap_up();
   end
endmodule // testbench

bind rpe_regs rpe_regs_props chk (.*);
